// >>> src/fpa_regs.svh
// Purpose: Offsets, field positions, codes and reset values of the flash
//          address, data and source registers and their control register.
// Assumes: Byte addresses on an 8-bit register port, one word per register.
// Notes:   Definitions only.
`ifndef FPA_REGS_SVH
`define FPA_REGS_SVH

// =====================================================================
// Register offsets
`define FPA_OFS_CTRL      8'h00
`define FPA_OFS_KEY       8'h10
`define FPA_OFS_TARGET    8'h20
`define FPA_OFS_DATA      8'h30
`define FPA_OFS_SRC       8'h40

// =====================================================================
// Control register fields
`define FPA_BIT_START     15
`define FPA_BIT_GATE      14
`define FPA_BIT_FAILED    13
`define FPA_OP_MSB        3
`define FPA_OP_LSB        0

// =====================================================================
// Operation select codes
`define FPA_OP_WORD       4'h1
`define FPA_OP_ROW        4'h3
`define FPA_OP_PAGE       4'h4
`define FPA_OP_ALL        4'h5

// =====================================================================
// Unlock key words, values are arbitrary
`define FPA_KEY_FIRST     32'h0000_A5A5
`define FPA_KEY_SECOND    32'h0000_5A5A

// =====================================================================
// Reset values
`define FPA_RST_WORD      32'h0000_0000
`define FPA_RST_OP        4'h0

`endif

// >>> src/fpa_pkg.sv
// Purpose: Types shared by the flash address and data register block.
// Assumes: One system clock.
// Notes:   Constants live in fpa_regs.svh.
package fpa_pkg;

  // ===================================================================
  // Sequencer states
  typedef enum logic [0:0] {ST_IDLE, ST_BUSY} fpa_state_type;

  // ===================================================================
  // Unlock progress
  typedef enum logic [1:0] {KEY_NONE, KEY_HALF, KEY_OPEN} fpa_key_type;

  // ===================================================================
  // Command towards the flash array
  typedef struct packed {
    logic        req;
    logic [3:0]  op;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] src;
  } fpa_cmd_type;

  // ===================================================================
  // Answer from the flash array
  typedef struct packed {
    logic done;
    logic fail;
    logic prot;
  } fpa_rsp_type;

  // ===================================================================
  // Whole state of the block
  typedef struct packed {
    fpa_state_type state;
    fpa_key_type   key;
    logic [3:0]    op_sel;
    logic          gate;
    logic          start;
    logic          failed;
    logic [31:0]   target;
    logic [31:0]   data;
    logic [31:0]   src;
    fpa_cmd_type   cmd;
    logic [31:0]   rdata;
  } fpa_core_type;

endpackage : fpa_pkg

// >>> src/fpa_flash_regs.sv
// Purpose: Target address, program data and row source registers with the
//          control and unlock logic that launches flash operations.
// Assumes: Flash array runs on sys_clk and answers with a one-cycle done.
// Notes:   Program data is cleared by por_b only.
`timescale 1ns/1ps
`default_nettype none
`include "fpa_regs.svh"

// How it works
// - Whole-array erase ignores the target address; zero is sent instead.
// - Page erase acts on the page named by the target address.
// - Row program acts on the row named by the target address.
// - Word program acts on the word named by the target address.
// - Target address is 32-bit read/write and clears to zero on reset.
// - Program data is a 32-bit read/write register holding flash data.
// - Program data clears on power-on reset only.
// - Source address is 32-bit read/write and clears to zero on reset.
// - Row program takes its data from the source address.
// - Operation codes 1 word, 3 row, 4 page, 5 all; protected skips.
// - Start launches the operation; hardware clears it on completion.
// - Start is writable only with launch gate set and unlock done.
// - Failure flag set on failed operation, clear on normal finish.
module fpa_flash_regs
  import fpa_pkg::*;
(
  // Clock and resets
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        por_b,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Flash array
  output fpa_cmd_type      flash_cmd,
  input  wire fpa_rsp_type flash_rsp,
  output logic             busy
);

  fpa_core_type st_r;
  fpa_core_type st_nxt;
  logic         op_known;
  logic         launch;

  // ===================================================================
  // Next state.
  always_comb
  begin
    st_nxt         = st_r;
    st_nxt.cmd.req = 1'b0;
    op_known       = (st_r.op_sel == `FPA_OP_WORD) ||
                     (st_r.op_sel == `FPA_OP_ROW)  ||
                     (st_r.op_sel == `FPA_OP_PAGE) ||
                     (st_r.op_sel == `FPA_OP_ALL);
    launch         = reg_wr && (reg_addr == `FPA_OFS_CTRL) &&
                     reg_wdata[`FPA_BIT_START] && st_r.gate &&
                     (st_r.key == KEY_OPEN) &&
                     (st_r.state == ST_IDLE);

    // Read answer, one cycle after the strobe.
    if (reg_rd)
    begin
      if (reg_addr == `FPA_OFS_CTRL)
      begin
        st_nxt.rdata = 32'h0000_0000;
        st_nxt.rdata[`FPA_BIT_START]  = st_r.start;
        st_nxt.rdata[`FPA_BIT_GATE]   = st_r.gate;
        st_nxt.rdata[`FPA_BIT_FAILED] = st_r.failed;
        st_nxt.rdata[`FPA_OP_MSB:`FPA_OP_LSB] = st_r.op_sel;
      end
      else if (reg_addr == `FPA_OFS_TARGET)
        st_nxt.rdata = st_r.target;
      else if (reg_addr == `FPA_OFS_DATA)
        st_nxt.rdata = st_r.data;
      else if (reg_addr == `FPA_OFS_SRC)
        st_nxt.rdata = st_r.src;
      else
        st_nxt.rdata = 32'h0000_0000;
    end

    // Unlock sequence, any other write closes it again.
    if (reg_wr)
    begin
      if (reg_addr == `FPA_OFS_KEY && reg_wdata == `FPA_KEY_FIRST)
        st_nxt.key = KEY_HALF;
      else if (reg_addr == `FPA_OFS_KEY && reg_wdata == `FPA_KEY_SECOND &&
               st_r.key == KEY_HALF)
        st_nxt.key = KEY_OPEN;
      else
        st_nxt.key = KEY_NONE;
    end

    // Register writes.
    if (reg_wr)
    begin
      if (reg_addr == `FPA_OFS_CTRL)
      begin
        st_nxt.gate = reg_wdata[`FPA_BIT_GATE];
        if (!st_r.gate)
          st_nxt.op_sel = reg_wdata[`FPA_OP_MSB:`FPA_OP_LSB];
      end
      else if (reg_addr == `FPA_OFS_TARGET)
        st_nxt.target = reg_wdata;
      else if (reg_addr == `FPA_OFS_DATA)
        st_nxt.data = reg_wdata;
      else if (reg_addr == `FPA_OFS_SRC)
        st_nxt.src = reg_wdata;
    end

    // Sequencer.
    case (st_r.state)
      ST_IDLE:
      begin
        if (launch)
        begin
          st_nxt.cmd.op    = st_r.op_sel;
          st_nxt.cmd.wdata = st_r.data;
          st_nxt.cmd.src   = st_r.src;
          if (st_r.op_sel == `FPA_OP_ALL)
            st_nxt.cmd.addr = 32'h0000_0000;
          else
            st_nxt.cmd.addr = st_r.target;
          if (st_r.op_sel == 4'h0)
            st_nxt.failed = 1'b0;
          else if (op_known && !flash_rsp.prot)
          begin
            st_nxt.cmd.req = 1'b1;
            st_nxt.start   = 1'b1;
            st_nxt.state   = ST_BUSY;
          end
        end
      end
      ST_BUSY:
      begin
        if (flash_rsp.done)
        begin
          st_nxt.start  = 1'b0;
          st_nxt.failed = flash_rsp.fail;
          st_nxt.state  = ST_IDLE;
        end
      end
      default:
        st_nxt.state = ST_IDLE;
    endcase

    // Resets: program data survives all but power-on reset.
    if (!rst_b || !por_b)
    begin
      st_nxt        = '0;
      st_nxt.op_sel = `FPA_RST_OP;
      st_nxt.data   = por_b ? st_r.data : `FPA_RST_WORD;
    end
  end

  // ===================================================================
  // State register.
  always_ff @(posedge sys_clk)
  begin
    st_r <= st_nxt;
  end

  assign reg_rdata = st_r.rdata;
  assign flash_cmd = st_r.cmd;
  assign busy      = (st_r.state == ST_BUSY);

  // ===================================================================
  // Checks.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b || !por_b);

  a_launch_issues_req: assert property (
    launch && op_known && !flash_rsp.prot |=>
      flash_cmd.req && st_r.start && busy)
    else $error("launch did not behave");

  a_refused_no_req: assert property (
    launch && !op_known |=> !flash_cmd.req && !busy && !st_r.start)
    else $error("unknown operation was launched");

  a_req_one_cycle: assert property (
    flash_cmd.req |=> !flash_cmd.req)
    else $error("request longer than one cycle");

  a_start_busy: assert property (
    st_r.start == busy)
    else $error("start bit and busy disagree");

  a_nop_clears: assert property (
    launch && st_r.op_sel == 4'h0 |=> !st_r.failed && !flash_cmd.req)
    else $error("no-operation launch did not clear failure");

  a_key_closes: assert property (
    reg_wr && reg_addr != `FPA_OFS_KEY |=> st_r.key == KEY_NONE)
    else $error("unlock stayed open after other write");

  a_op_locked: assert property (
    st_r.gate |=> st_r.op_sel == $past(st_r.op_sel))
    else $error("operation select changed while gated");

  a_target_held: assert property (
    !(reg_wr && reg_addr == `FPA_OFS_TARGET) |=>
      st_r.target == $past(st_r.target))
    else $error("target changed without a write");

  a_data_held: assert property (
    !(reg_wr && reg_addr == `FPA_OFS_DATA) |=>
      st_r.data == $past(st_r.data))
    else $error("data changed without a write");

  a_src_held: assert property (
    !(reg_wr && reg_addr == `FPA_OFS_SRC) |=>
      st_r.src == $past(st_r.src))
    else $error("source changed without a write");

  a_target_readback: assert property (
    reg_wr && reg_addr == `FPA_OFS_TARGET ##1 reg_rd &&
      reg_addr == `FPA_OFS_TARGET && !reg_wr |=>
      reg_rdata == $past(reg_wdata, 2))
    else $error("target register readback wrong");

  a_src_readback: assert property (
    reg_wr && reg_addr == `FPA_OFS_SRC ##1 reg_rd &&
      reg_addr == `FPA_OFS_SRC && !reg_wr |=>
      reg_rdata == $past(reg_wdata, 2))
    else $error("source register readback wrong");

  a_key_reads_zero: assert property (
    reg_rd && reg_addr == `FPA_OFS_KEY |=> reg_rdata == 32'h0000_0000)
    else $error("key register read not zero");

  a_req_only_idle: assert property (
    busy |=> !flash_cmd.req)
    else $error("second request while busy");

  a_erase_all_addr: assert property (
    flash_cmd.req && flash_cmd.op == `FPA_OP_ALL |->
      flash_cmd.addr == 32'h0000_0000)
    else $error("whole erase sent an address");

  a_page_row_addr: assert property (
    launch && st_r.op_sel != `FPA_OP_ALL && !flash_rsp.prot && op_known
      |=> flash_cmd.req && flash_cmd.addr == $past(st_r.target))
    else $error("target address not used");

  a_word_data: assert property (
    launch && st_r.op_sel == `FPA_OP_WORD && !flash_rsp.prot
      |=> flash_cmd.wdata == $past(st_r.data))
    else $error("word data not sampled");

  a_row_source: assert property (
    launch && st_r.op_sel == `FPA_OP_ROW && !flash_rsp.prot
      |=> flash_cmd.src == $past(st_r.src))
    else $error("row source not sampled");

  a_cmd_held: assert property (
    busy && !flash_rsp.done |=> $stable(flash_cmd.addr) &&
      $stable(flash_cmd.wdata) && $stable(flash_cmd.src))
    else $error("command changed mid operation");

  a_start_gated: assert property (
    !st_r.start && (!st_r.gate || st_r.key != KEY_OPEN) |=> !st_r.start)
    else $error("start set without gate or unlock");

  a_done_flags: assert property (
    busy && flash_rsp.done |=> !st_r.start && !busy &&
      st_r.failed == $past(flash_rsp.fail))
    else $error("completion flags wrong");

  a_data_readback: assert property (
    reg_wr && reg_addr == `FPA_OFS_DATA ##1 reg_rd &&
      reg_addr == `FPA_OFS_DATA && !reg_wr |=>
      reg_rdata == $past(reg_wdata, 2))
    else $error("data register readback wrong");

  a_data_keeps: assert property (
    @(posedge sys_clk) disable iff (!por_b)
    !rst_b |=> st_r.data == $past(st_r.data) &&
      st_r.target == 32'h0000_0000 && st_r.src == 32'h0000_0000)
    else $error("reset handling of registers wrong");

  a_protected_skip: assert property (
    launch && flash_rsp.prot |=> !flash_cmd.req && !busy)
    else $error("protected region not skipped");

endmodule : fpa_flash_regs

`default_nettype wire

// >>> verification/fpa_flash_model.sv
// Purpose: Behavioural flash array that answers launched operations.
// Assumes: Same clock as the register block; done is a one-cycle pulse.
// Notes:   Delay, failure and protection are chosen by the bench.
`timescale 1ns/1ps
`default_nettype none
module fpa_flash_model
  import fpa_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // Bench controls
  input  wire logic [7:0] dly,
  input  wire logic       fail_in,
  input  wire logic       prot_in,
  // Register block link
  input  wire fpa_cmd_type cmd,
  output fpa_rsp_type      rsp
);
  logic [7:0] cnt_r;
  logic       run_r;

  // ===================================================================
  // Operation timing
  always_ff @(posedge sys_clk)
  begin
    rsp      <= '0;
    rsp.prot <= prot_in;
    if (!rst_b)
    begin
      run_r <= 1'b0;
      cnt_r <= 8'h00;
    end
    else if (cmd.req)
    begin
      run_r <= 1'b1;
      cnt_r <= dly;
    end
    else if (run_r && cnt_r == 8'h00)
    begin
      run_r    <= 1'b0;
      rsp.done <= 1'b1;
      rsp.fail <= fail_in;
    end
    else if (run_r)
      cnt_r <= cnt_r - 8'h01;
  end
endmodule : fpa_flash_model
`default_nettype wire

// >>> verification/fpa_flash_regs_tb_top.sv
// Purpose: Register and launch tests of the flash address register block.
// Assumes: Flash array model answers after a bench-chosen delay.
// Notes:   Each test prints one line when it ends.
`timescale 1ns/1ps
`default_nettype none
`include "fpa_regs.svh"
module fpa_flash_regs_tb_top
  import fpa_pkg::*;
;
  logic        sys_clk     = 1'b0;
  logic        rst_b       = 1'b0;
  logic        por_b       = 1'b0;
  logic [7:0]  reg_addr    = 8'h00;
  logic [31:0] reg_wdata   = 32'h0;
  logic        reg_wr      = 1'b0;
  logic        reg_rd      = 1'b0;
  logic [7:0]  dly         = 8'h02;
  logic        fail_in     = 1'b0;
  logic        prot_in     = 1'b0;
  logic [31:0] reg_rdata;
  fpa_cmd_type flash_cmd;
  fpa_rsp_type flash_rsp;
  logic        busy;
  logic [31:0] v;
  logic [31:0] e;
  int          n_mismatch  = 0;
  int          comparisons = 0;
  int          n_req       = 0;
  logic [3:0]  ops [4]     = '{`FPA_OP_WORD, `FPA_OP_ROW, `FPA_OP_PAGE,
                               `FPA_OP_ALL};

  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (flash_cmd.req === 1'b1) n_req++;

  fpa_flash_regs dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .por_b(por_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_cmd(flash_cmd),
    .flash_rsp(flash_rsp), .busy(busy));
  fpa_flash_model fm_u (.sys_clk(sys_clk), .rst_b(rst_b), .dly(dly),
    .fail_in(fail_in), .prot_in(prot_in), .cmd(flash_cmd), .rsp(flash_rsp));

  // ===================================================================
  // Access tasks
  task automatic chk(input string w, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", w, x, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd
  task automatic wr_rd(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b1;
    @(posedge sys_clk);
    reg_rd    <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : wr_rd
  task automatic launch(input logic [3:0] op, input logic keys);
    wr(`FPA_OFS_CTRL, 32'h0);
    wr(`FPA_OFS_CTRL, 32'h0000_4000 | {28'h0, op});
    if (keys)
    begin
      wr(`FPA_OFS_KEY, `FPA_KEY_FIRST);
      wr(`FPA_OFS_KEY, `FPA_KEY_SECOND);
    end
    wr(`FPA_OFS_CTRL, 32'h0000_C000 | {28'h0, op});
    #1;
    for (int i = 0; i < 4 && flash_cmd.req !== 1'b1; i++) @(posedge sys_clk) #1;
  endtask : launch
  task automatic wait_idle();
    for (int i = 0; i < 60 && busy !== 1'b0; i++) @(posedge sys_clk) #1;
    rd(`FPA_OFS_CTRL);
    chk("start", 32'h0, {31'h0, v[`FPA_BIT_START]});
  endtask : wait_idle
  task automatic stop_test();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  initial
  begin
    repeat (5000) @(posedge sys_clk);
    n_mismatch++;
    $display("[ERR] watchdog expired");
    stop_test();
  end

  // ===================================================================
  // Tests
  initial
  begin
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    por_b <= 1'b1;
    rd(`FPA_OFS_TARGET); chk("target", 32'h0, v);
    rd(`FPA_OFS_DATA);   chk("data", 32'h0, v);
    rd(`FPA_OFS_SRC);    chk("src", 32'h0, v);
    wr_rd(`FPA_OFS_DATA, 32'h1234_ABCD);   chk("data", 32'h1234_ABCD, v);
    wr_rd(`FPA_OFS_TARGET, 32'h0F1E_2D3C); chk("target", 32'h0F1E_2D3C, v);
    wr_rd(`FPA_OFS_SRC, 32'h3C2D_1E0F);    chk("src", 32'h3C2D_1E0F, v);
    wr(`FPA_OFS_TARGET, 32'hA5C3_0F0F);
    wr(`FPA_OFS_DATA, 32'h5A3C_F0F0);
    wr(`FPA_OFS_SRC, 32'hFFFF_0001);
    rd(`FPA_OFS_TARGET); chk("target", 32'hA5C3_0F0F, v);
    rd(`FPA_OFS_DATA);   chk("data", 32'h5A3C_F0F0, v);
    rd(`FPA_OFS_SRC);    chk("src", 32'hFFFF_0001, v);
    $display("test registers done");
    for (int i = 0; i < 4; i++)
    begin
      wr(`FPA_OFS_TARGET, 32'h0001_0000 + 32'(i));
      wr(`FPA_OFS_DATA, 32'hC0DE_0000 + 32'(i));
      wr(`FPA_OFS_SRC, 32'h2000_0100 + 32'(i));
      launch(ops[i], 1'b1);
      e = (ops[i] == `FPA_OP_ALL) ? 32'h0 : 32'h0001_0000 + 32'(i);
      chk("req", 32'h1, {31'h0, flash_cmd.req});
      chk("op", {28'h0, ops[i]}, {28'h0, flash_cmd.op});
      chk("addr", e, flash_cmd.addr);
      chk("wdata", 32'hC0DE_0000 + 32'(i), flash_cmd.wdata);
      chk("src", 32'h2000_0100 + 32'(i), flash_cmd.src);
      wait_idle();
    end
    $display("test operations done");
    dly <= 8'h14;
    launch(`FPA_OP_WORD, 1'b1);
    wr(`FPA_OFS_TARGET, 32'h0000_0BAD);
    wr(`FPA_OFS_DATA, 32'h0000_0BAD);
    rd(`FPA_OFS_CTRL); chk("start", 32'h1, {31'h0, v[`FPA_BIT_START]});
    chk("held addr", 32'h0001_0003, flash_cmd.addr);
    chk("held wdata", 32'hC0DE_0003, flash_cmd.wdata);
    wait_idle();
    dly <= 8'h02;
    fail_in <= 1'b1;
    launch(`FPA_OP_PAGE, 1'b1);
    wait_idle();
    chk("failed", 32'h1, {31'h0, v[`FPA_BIT_FAILED]});
    fail_in <= 1'b0;
    launch(`FPA_OP_PAGE, 1'b1);
    wait_idle();
    chk("failed", 32'h0, {31'h0, v[`FPA_BIT_FAILED]});
    fail_in <= 1'b1;
    launch(`FPA_OP_PAGE, 1'b1);
    wait_idle();
    chk("failed", 32'h1, {31'h0, v[`FPA_BIT_FAILED]});
    fail_in <= 1'b0;
    launch(4'h0, 1'b1);
    rd(`FPA_OFS_CTRL);
    chk("failed", 32'h0, {31'h0, v[`FPA_BIT_FAILED]});
    $display("test launch done");
    e = 32'(n_req);
    launch(`FPA_OP_WORD, 1'b0);
    launch(4'h6, 1'b1);
    prot_in <= 1'b1;
    launch(`FPA_OP_WORD, 1'b1);
    prot_in <= 1'b0;
    wait_idle();
    chk("req count", e, 32'(n_req));
    $display("test refusals done");
    @(posedge sys_clk);
    rst_b <= 1'b0;
    @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(`FPA_OFS_DATA);   chk("data", 32'h0000_0BAD, v);
    rd(`FPA_OFS_TARGET); chk("target", 32'h0, v);
    rd(`FPA_OFS_SRC);    chk("src", 32'h0, v);
    @(posedge sys_clk);
    por_b <= 1'b0;
    @(posedge sys_clk);
    por_b <= 1'b1;
    rd(`FPA_OFS_DATA);   chk("data", 32'h0, v);
    $display("test resets done");
    stop_test();
  end
endmodule : fpa_flash_regs_tb_top
`default_nettype wire
